// ---- hdl/mcr_pkg.sv ----
// constants for the clock, power and reset sequencer of the microcontroller
// assumes one clock, clk_sys_i, standing in for the oscillator input
// What this block does
// [RULE1] The oscillator clock is halved before any internal use.
// [RULE2] Setting the idle request bit of the power control register enters idle mode.
// [RULE3] In idle the processor clock stops while peripherals and interrupt logic run.
// [RULE4] An interrupt or a reset ends idle mode and restores the processor clock.
// [RULE5] Setting the power-down request bit stops every clock including the oscillator.
// [RULE6] Only a reset ends power-down mode; interrupts are ignored there.
// [RULE7] The reset pin is sampled at state 5 phase 2 of each machine cycle.
// [RULE8] The reset source holds the pin high for two full machine cycles with the clock running.
// [RULE9] The reset pin is filtered so that short glitches cause no reset.
// [RULE10] During reset all port latches are set to all ones and the stack pointer to seven.
// [RULE11] During reset the power control register is cleared except bit 4, which is kept.
// [RULE12] During reset other special registers clear, the serial buffer is left alone.
// [RULE13] The address latch strobe runs at a sixth of the oscillator rate, one pulse skipped per data access.
// [RULE14] During reset both strobes are released to high impedance with a weak pull-up.
// [RULE15] All state is static; the clock may stop anywhere without loss.
// [RULE16] A machine cycle is six states of two phases, twelve oscillator periods.
package mcr_pkg;
    // last state of a machine cycle and last phase position within it
    localparam logic [2:0] STATE_LAST = 3'h5;
    localparam logic [3:0] POS_LAST = 4'hB;
    // state 5 phase 2, counted from zero
    localparam logic [2:0] SAMPLE_STATE = 3'h4;
    localparam logic SAMPLE_PHASE = 1'b1;
    // strobe windows as phase positions within a machine cycle
    localparam logic [3:0] ALE_FIRST_POS = 4'h0;
    localparam logic [3:0] ALE_SECOND_POS = 4'h6;
    localparam logic [3:0] ALE_LEN = 4'h2;
    localparam logic [3:0] FETCH_FIRST_POS = 4'h3;
    localparam logic [3:0] FETCH_SECOND_POS = 4'h9;
    localparam logic [3:0] FETCH_LEN = 4'h3;
    // power control register layout and reset values
    localparam int IDLE_BIT = 0;
    localparam int PD_BIT = 1;
    localparam int POWER_CONTROL_REG_KEEP_BIT = 4;
    localparam logic [7:0] POWER_CONTROL_REG_RST = 8'h00;
    localparam logic [7:0] PORT_RST = 8'hFF;
    localparam logic [3:0] PORT4_RST = 4'hF;
    localparam logic [7:0] SP_RST = 8'h07;
    localparam logic [7:0] SFR_RST = 8'h00;
    localparam logic [7:0] SERIAL_BUFFER_REG_POWERON = 8'h00;
    localparam int NUM_PORTS = 4;
    localparam logic [1:0] FILTER_SAMPLES = 2'h2;
    // gray coded along run, idle, power-down
    typedef enum logic [1:0] {
        MCR_RUN = 2'b00,
        MCR_IDLE = 2'b01,
        MCR_DOWN = 2'b11
    } mcr_pwr_type;
endpackage : mcr_pkg

// ---- hdl/mcr_rst_filter.sv ----
// reset pin filter: two agreeing samples at the sample point change the level
// assumes sample_i pulses once per machine cycle while the oscillator runs
`timescale 1ns/100ps
module mcr_rst_filter (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic sample_i,
    input wire logic pin_i,
    output logic rst_o
);
    logic [1:0] hist_r;

    // [RULE9] history of pin samples
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            hist_r <= 2'h0;
        end else if (sample_i) begin
            hist_r <= {hist_r[0], pin_i};
        end
    end

    // [RULE9] a lone sample never flips the level
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            rst_o <= 1'b0;
        end else if (sample_i && hist_r[0] && pin_i) begin
            rst_o <= 1'b1;
        end else if (sample_i && !hist_r[0] && !pin_i) begin
            rst_o <= 1'b0;
        end
    end

    // [RULE8] reset accepted only after two samples a machine cycle apart
    rise_two_samples_a: assert property ( // [RULE8]
        @(posedge clk_sys_i) disable iff (reset_i)
        $rose(rst_o) |-> $past(sample_i, 1) && $past(pin_i, 1) && $past(hist_r[0], 1))
        else $error("reset taken without two high samples");

    // [RULE9] a single high sample leaves reset low
    glitch_ignored_a: assert property ( // [RULE9]
        @(posedge clk_sys_i) disable iff (reset_i)
        (sample_i && pin_i && !hist_r[0] && !rst_o) |=> !rst_o)
        else $error("single sample raised reset");
endmodule : mcr_rst_filter

// ---- hdl/mcr_ctrl.sv ----
// clock halving, machine-cycle timing, power modes and reset sequencing
// assumes clk_sys_i is the oscillator input and the core obeys the clock enables
`timescale 1ns/100ps
module mcr_ctrl (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic rst_pin_i,
    input wire logic irq_i,
    input wire logic xdata_access_i,
    input wire logic code_fetch_i,
    input wire logic power_control_reg_wr_i,
    input wire logic sp_wr_i,
    input wire logic port_wr_i,
    input wire logic [1:0] port_sel_i,
    input wire logic port4_wr_i,
    input wire logic sfr_gen_wr_i,
    input wire logic serial_buffer_reg_wr_i,
    input wire logic [7:0] wdata_i,
    output logic int_clk_o,
    output logic [2:0] state_o,
    output logic core_clk_en_o,
    output logic periph_clk_en_o,
    output logic osc_en_o,
    output logic reset_o,
    output logic idle_o,
    output logic powerdown_o,
    output logic [31:0] port_latch_o,
    output logic [3:0] port4_latch_o,
    output logic [7:0] sp_o,
    output logic [7:0] power_control_reg_o,
    output logic [7:0] sfr_gen_o,
    output logic [7:0] serial_buffer_reg_o,
    output logic ale_o,
    output logic ale_oe_o,
    output logic program_store_strobe_n_o,
    output logic program_store_strobe_oe_o
);
    logic half_r;
    logic [2:0] state_r;
    mcr_pkg::mcr_pwr_type pwr_r;
    mcr_pkg::mcr_pwr_type pwr_nxt;
    logic run_w;
    logic state5_phase2_sample_point;
    logic pin_rst_w;
    logic rst_w;
    logic [3:0] pos_w;
    logic ale_nxt;
    logic strobe_n_nxt;
    logic wake_w;

    function automatic logic in_window(input logic [3:0] pos, input logic [3:0] start,
                                       input logic [3:0] len);
        in_window = (pos >= start) && (pos < start + len);
    endfunction : in_window

    // oscillator stands still in power-down unless the reset pin wakes it
    assign run_w = (pwr_r != mcr_pkg::MCR_DOWN) || rst_pin_i;
    assign pos_w = {state_r, half_r};
    assign rst_w = reset_i || pin_rst_w;
    assign wake_w = irq_i;

    // [RULE1] halved clock: one phase per oscillator period
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            half_r <= 1'b0;
        end else if (run_w) begin
            half_r <= !half_r;
        end
    end

    // [RULE16] six states of two phases each
    // [RULE15] counter only holds while stopped, nothing decays
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            state_r <= 3'h0;
        end else if (run_w && half_r) begin
            state_r <= (state_r == mcr_pkg::STATE_LAST) ? 3'h0 : state_r + 3'h1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            int_clk_o <= 1'b0;
            state_o <= 3'h0;
        end else begin
            int_clk_o <= half_r;
            state_o <= state_r;
        end
    end

    // [RULE7] reset pin sampled once per machine cycle
    assign state5_phase2_sample_point = run_w && (state_r == mcr_pkg::SAMPLE_STATE)
                                        && (half_r == mcr_pkg::SAMPLE_PHASE);

    mcr_rst_filter u_filter (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .sample_i(state5_phase2_sample_point),
        .pin_i(rst_pin_i),
        .rst_o(pin_rst_w)
    );

    always_ff @(posedge clk_sys_i) begin
        reset_o <= rst_w;
    end

    // power mode selection
    always_comb begin
        pwr_nxt = pwr_r;
        case (pwr_r)
            mcr_pkg::MCR_RUN: begin
                // [RULE5] power-down wins over idle
                if (power_control_reg_o[mcr_pkg::PD_BIT]) begin
                    pwr_nxt = mcr_pkg::MCR_DOWN;
                // [RULE2] idle request bit
                end else if (power_control_reg_o[mcr_pkg::IDLE_BIT]) begin
                    pwr_nxt = mcr_pkg::MCR_IDLE;
                end
            end
            mcr_pkg::MCR_IDLE: begin
                // [RULE4] interrupt ends idle
                if (wake_w) begin
                    pwr_nxt = mcr_pkg::MCR_RUN;
                end
            end
            mcr_pkg::MCR_DOWN: begin
                // [RULE6] interrupts ignored, only reset leaves
                pwr_nxt = mcr_pkg::MCR_DOWN;
            end
            default: begin
                pwr_nxt = mcr_pkg::MCR_RUN;
            end
        endcase
    end

    // [RULE4] reset always returns to run
    always_ff @(posedge clk_sys_i) begin
        if (rst_w) begin
            pwr_r <= mcr_pkg::MCR_RUN;
        end else begin
            pwr_r <= pwr_nxt;
        end
    end

    // [RULE3] core clock gated, peripherals still clocked in idle
    always_ff @(posedge clk_sys_i) begin
        if (rst_w) begin
            core_clk_en_o <= 1'b1;
            periph_clk_en_o <= 1'b1;
            osc_en_o <= 1'b1;
            idle_o <= 1'b0;
            powerdown_o <= 1'b0;
        end else begin
            core_clk_en_o <= (pwr_nxt == mcr_pkg::MCR_RUN);
            // [RULE5] every clock off in power-down
            periph_clk_en_o <= (pwr_nxt != mcr_pkg::MCR_DOWN);
            osc_en_o <= (pwr_nxt != mcr_pkg::MCR_DOWN);
            idle_o <= (pwr_nxt == mcr_pkg::MCR_IDLE);
            powerdown_o <= (pwr_nxt == mcr_pkg::MCR_DOWN);
        end
    end

    // [RULE11] power control register, bit 4 survives a pin reset, reset_i clears it
    always_ff @(posedge clk_sys_i) begin
        if (rst_w) begin
            power_control_reg_o <= mcr_pkg::POWER_CONTROL_REG_RST;
            power_control_reg_o[mcr_pkg::POWER_CONTROL_REG_KEEP_BIT] <=
                reset_i ? 1'b0 : power_control_reg_o[mcr_pkg::POWER_CONTROL_REG_KEEP_BIT];
        end else if (power_control_reg_wr_i && pwr_r == mcr_pkg::MCR_RUN) begin
            power_control_reg_o <= wdata_i;
        // [RULE4] leaving idle drops the request bit so the core runs on
        end else if (pwr_r == mcr_pkg::MCR_IDLE && wake_w) begin
            power_control_reg_o[mcr_pkg::IDLE_BIT] <= 1'b0;
        end
    end

    // [RULE10] port latches set to all ones
    generate
        for (genvar p = 0; p < mcr_pkg::NUM_PORTS; p++) begin : g_port
            always_ff @(posedge clk_sys_i) begin
                if (rst_w) begin
                    port_latch_o[p*8 +: 8] <= mcr_pkg::PORT_RST;
                end else if (port_wr_i && port_sel_i == 2'(p)
                             && pwr_r == mcr_pkg::MCR_RUN) begin
                    port_latch_o[p*8 +: 8] <= wdata_i;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys_i) begin
        if (rst_w) begin
            port4_latch_o <= mcr_pkg::PORT4_RST;
        end else if (port4_wr_i && pwr_r == mcr_pkg::MCR_RUN) begin
            port4_latch_o <= wdata_i[3:0];
        end
    end

    // [RULE10] stack pointer to seven
    always_ff @(posedge clk_sys_i) begin
        if (rst_w) begin
            sp_o <= mcr_pkg::SP_RST;
        end else if (sp_wr_i && pwr_r == mcr_pkg::MCR_RUN) begin
            sp_o <= wdata_i;
        end
    end

    // [RULE12] other special registers clear
    always_ff @(posedge clk_sys_i) begin
        if (rst_w) begin
            sfr_gen_o <= mcr_pkg::SFR_RST;
        end else if (sfr_gen_wr_i && pwr_r == mcr_pkg::MCR_RUN) begin
            sfr_gen_o <= wdata_i;
        end
    end

    // [RULE12] serial buffer untouched by the reset pin, cleared at power-on only
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            serial_buffer_reg_o <= mcr_pkg::SERIAL_BUFFER_REG_POWERON;
        end else if (serial_buffer_reg_wr_i && pwr_r != mcr_pkg::MCR_DOWN) begin
            serial_buffer_reg_o <= wdata_i;
        end
    end

    // [RULE13] two pulses per machine cycle, second one dropped on data access
    always_comb begin
        ale_nxt = in_window(pos_w, mcr_pkg::ALE_FIRST_POS, mcr_pkg::ALE_LEN)
                  || (in_window(pos_w, mcr_pkg::ALE_SECOND_POS, mcr_pkg::ALE_LEN)
                      && !xdata_access_i);
        strobe_n_nxt = !(code_fetch_i
                         && (in_window(pos_w, mcr_pkg::FETCH_FIRST_POS, mcr_pkg::FETCH_LEN)
                             || in_window(pos_w, mcr_pkg::FETCH_SECOND_POS,
                                          mcr_pkg::FETCH_LEN)));
    end

    // [RULE14] strobes float high during reset
    always_ff @(posedge clk_sys_i) begin
        if (rst_w) begin
            ale_o <= 1'b1;
            ale_oe_o <= 1'b0;
            program_store_strobe_n_o <= 1'b1;
            program_store_strobe_oe_o <= 1'b0;
        end else begin
            ale_oe_o <= 1'b1;
            program_store_strobe_oe_o <= 1'b1;
            // frozen oscillator leaves the strobes where they stood
            if (run_w) begin
                ale_o <= ale_nxt;
                program_store_strobe_n_o <= strobe_n_nxt;
            end
        end
    end

    half_clock_a: assert property ( // [RULE1]
        @(posedge clk_sys_i) disable iff (reset_i)
        run_w |=> half_r != $past(half_r))
        else $error("internal phase did not alternate");

    idle_gating_a: assert property ( // [RULE3]
        @(posedge clk_sys_i) disable iff (reset_i)
        (pwr_r == mcr_pkg::MCR_IDLE && !reset_o) |=> !core_clk_en_o && periph_clk_en_o
                                                    || reset_o || $past(irq_i))
        else $error("idle clock gating wrong");

    idle_wake_a: assert property ( // [RULE4]
        @(posedge clk_sys_i) disable iff (reset_i)
        (pwr_r == mcr_pkg::MCR_IDLE && irq_i) |=> pwr_r == mcr_pkg::MCR_RUN ##1 core_clk_en_o)
        else $error("interrupt did not end idle");

    pd_entry_a: assert property ( // [RULE5]
        @(posedge clk_sys_i) disable iff (rst_w)
        (pwr_r == mcr_pkg::MCR_RUN && power_control_reg_o[mcr_pkg::PD_BIT])
            |=> !osc_en_o && !periph_clk_en_o && !core_clk_en_o)
        else $error("clocks still on in power-down");

    pd_no_wake_a: assert property ( // [RULE6]
        @(posedge clk_sys_i) disable iff (rst_w)
        (pwr_r == mcr_pkg::MCR_DOWN && irq_i) |=> pwr_r == mcr_pkg::MCR_DOWN)
        else $error("interrupt woke power-down");

    sample_timing_a: assert property ( // [RULE7]
        @(posedge clk_sys_i) disable iff (reset_i)
        state5_phase2_sample_point && pwr_r != mcr_pkg::MCR_DOWN
            |-> ##12 state5_phase2_sample_point || !run_w || $past(!run_w, 11))
        else $error("sample point not once per machine cycle");

    reset_values_a: assert property ( // [RULE10]
        @(posedge clk_sys_i) disable iff (reset_i)
        reset_o |-> sp_o == mcr_pkg::SP_RST && port_latch_o == {4{mcr_pkg::PORT_RST}}
                    && sfr_gen_o == mcr_pkg::SFR_RST)
        else $error("reset values not loaded");

    power_control_reg_keep_a: assert property ( // [RULE11]
        @(posedge clk_sys_i) disable iff (reset_i)
        (reset_o && $past(reset_o)) |-> $stable(power_control_reg_o[mcr_pkg::POWER_CONTROL_REG_KEEP_BIT])
            && (power_control_reg_o & 8'hEF) == mcr_pkg::POWER_CONTROL_REG_RST)
        else $error("power control reset wrong");

    serial_buffer_reg_kept_a: assert property ( // [RULE12]
        @(posedge clk_sys_i) disable iff (reset_i)
        (reset_o && !serial_buffer_reg_wr_i) |=> $stable(serial_buffer_reg_o))
        else $error("serial buffer disturbed by reset");

    ale_width_a: assert property ( // [RULE13]
        @(posedge clk_sys_i) disable iff (rst_w || reset_o)
        ($rose(ale_o) && $past(run_w) && run_w && $past(!reset_o)) |=> ale_o ##1 !ale_o || !run_w)
        else $error("address strobe width wrong");

    strobe_float_a: assert property ( // [RULE14]
        @(posedge clk_sys_i) disable iff (reset_i)
        reset_o |-> !ale_oe_o && !program_store_strobe_oe_o && ale_o && program_store_strobe_n_o)
        else $error("strobes driven during reset");
endmodule : mcr_ctrl

// ---- dv/mcr_rst_src.sv ----
// far-side model: external reset source and interrupt source of the core
// assumes the bench calls its tasks; all changes land just after a rising edge
`timescale 1ns/100ps
module mcr_rst_src (
    input wire logic clk_sys_i,
    output logic rst_pin_o,
    output logic irq_o
);
    initial begin
        rst_pin_o = 1'b0;
        irq_o = 1'b0;
    end

    // pin held high
    // a hold shorter than one machine cycle is a deliberate glitch
    task automatic hold_pin(input int cycles);
        @(posedge clk_sys_i);
        rst_pin_o <= 1'b1;
        repeat (cycles) @(posedge clk_sys_i);
        rst_pin_o <= 1'b0;
    endtask : hold_pin

    task automatic raise_irq();
        @(posedge clk_sys_i);
        irq_o <= 1'b1;
        @(posedge clk_sys_i);
        irq_o <= 1'b0;
    endtask : raise_irq
endmodule : mcr_rst_src

// ---- dv/mcr_ctrl_tb.sv ----
// self-checking bench for the clock, power and reset sequencer
// assumes mcr_ctrl and mcr_pkg compiled first; far side is mcr_rst_src
`timescale 1ns/100ps
module mcr_ctrl_tb;
    typedef struct {int id; logic [31:0] exp;} mcr_note_type;
    localparam int ID_PORT = 0, ID_SP = 1, ID_POWER_CONTROL_REG = 2, ID_SFR = 3, ID_SERIAL_BUFFER_REG = 4, ID_P4 = 5;
    localparam int ID_IDLE = 6, ID_PD = 7, ID_CORE = 8, ID_OSC = 9, ID_RST = 10;
    localparam int ID_PERI = 11, ID_ALEOE = 12, ID_PSOE = 13, ID_ALEN = 14, ID_LOWN = 15;
    localparam int ID_TOGN = 16, ID_MC = 17;
    localparam int W_POWER_CONTROL_REG = 0, W_SP = 1, W_PORT = 2, W_P4 = 3, W_SFR = 4, W_SERIAL_BUFFER_REG = 5;
    logic clk_sys_i, reset_i, rst_pin, irq, xdata_access, code_fetch, cnt_clr;
    logic [5:0] wr_vec;
    logic [1:0] port_sel;
    logic [7:0] wdata, sp, power_control_reg, sfr_gen, serial_buffer_reg, exp_sp, exp_serial_buffer_reg, exp_sfr;
    logic int_clk, core_en, periph_en, osc_en, reset_o, idle, powerdown;
    logic ale, ale_oe, program_store_strobe_n, program_store_strobe_oe, ale_prev, clk_prev;
    logic [2:0] state, state_prev;
    logic [31:0] port_latch, exp_port, rnd;
    logic [3:0] port4, exp_p4;
    int ale_cnt = 0, low_cnt = 0, tog_cnt = 0, mc_cnt = 0, errors = 0, checked = 0;
    mcr_note_type notes[$];

    mcr_ctrl dut_u (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .rst_pin_i(rst_pin),
        .irq_i(irq), .xdata_access_i(xdata_access), .code_fetch_i(code_fetch),
        .power_control_reg_wr_i(wr_vec[0]), .sp_wr_i(wr_vec[1]), .port_wr_i(wr_vec[2]),
        .port_sel_i(port_sel), .port4_wr_i(wr_vec[3]), .sfr_gen_wr_i(wr_vec[4]),
        .serial_buffer_reg_wr_i(wr_vec[5]), .wdata_i(wdata), .int_clk_o(int_clk), .state_o(state),
        .core_clk_en_o(core_en), .periph_clk_en_o(periph_en), .osc_en_o(osc_en),
        .reset_o(reset_o), .idle_o(idle), .powerdown_o(powerdown),
        .port_latch_o(port_latch), .port4_latch_o(port4), .sp_o(sp),
        .power_control_reg_o(power_control_reg), .sfr_gen_o(sfr_gen), .serial_buffer_reg_o(serial_buffer_reg),
        .ale_o(ale), .ale_oe_o(ale_oe), .program_store_strobe_n_o(program_store_strobe_n),
        .program_store_strobe_oe_o(program_store_strobe_oe));

    mcr_rst_src partner_u (.clk_sys_i(clk_sys_i), .rst_pin_o(rst_pin), .irq_o(irq));

    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [31:0] out_of(input int id);
        case (id)
            ID_PORT: return port_latch;
            ID_SP: return {24'h000000, sp};
            ID_POWER_CONTROL_REG: return {24'h000000, power_control_reg};
            ID_SFR: return {24'h000000, sfr_gen};
            ID_SERIAL_BUFFER_REG: return {24'h000000, serial_buffer_reg};
            ID_P4: return {28'h0000000, port4};
            ID_IDLE: return {31'h00000000, idle};
            ID_PD: return {31'h00000000, powerdown};
            ID_CORE: return {31'h00000000, core_en};
            ID_OSC: return {31'h00000000, osc_en};
            ID_RST: return {31'h00000000, reset_o};
            ID_PERI: return {31'h00000000, periph_en};
            ID_ALEOE: return {31'h00000000, ale_oe};
            ID_PSOE: return {31'h00000000, program_store_strobe_oe};
            ID_ALEN: return 32'(ale_cnt);
            ID_LOWN: return 32'(low_cnt);
            ID_MC: return 32'(mc_cnt);
            default: return 32'(tog_cnt);
        endcase
    endfunction : out_of

    task automatic compare_val(input logic [31:0] exp, input logic [31:0] act);
        checked++;
        if (act !== exp) begin
            errors++;
            $display("[ERR] %0t exp=%0h act=%0h", $time, exp, act);
        end
    endtask : compare_val

    task automatic compare_flag(input logic exp, input logic act);
        checked++;
        if (act !== exp) begin
            errors++;
            $display("[ERR] %0t exp=%0h act=%0h", $time, exp, act);
        end
    endtask : compare_flag

    // outputs change only on rising edges, so the falling edge sees them settled
    always @(negedge clk_sys_i) begin
        mcr_note_type n;
        logic [31:0] act;
        while (notes.size() > 0) begin
            n = notes.pop_front();
            act = out_of(n.id);
            if (n.id >= ID_IDLE && n.id <= ID_PSOE) begin
                compare_flag(n.exp[0], act[0]);
            end else begin
                compare_val(n.exp, act);
            end
        end
    end

    // strobe, clock and machine-cycle counters; non-blocking so the monitor reads the closed window
    always @(negedge clk_sys_i) begin
        ale_prev <= ale;
        clk_prev <= int_clk;
        state_prev <= state;
        if (cnt_clr === 1'b1) begin
            ale_cnt <= 0;
            low_cnt <= 0;
            tog_cnt <= 0;
            mc_cnt <= 0;
        end else begin
            if (state === 3'h0 && state_prev === mcr_pkg::STATE_LAST) mc_cnt <= mc_cnt + 1;
            if (ale === 1'b1 && ale_prev === 1'b0) ale_cnt <= ale_cnt + 1;
            if (program_store_strobe_n === 1'b0) low_cnt <= low_cnt + 1;
            if (int_clk !== clk_prev) tog_cnt <= tog_cnt + 1;
        end
    end

    task automatic note_exp(input int id, input logic [31:0] v);
        notes.push_back('{id, v});
    endtask : note_exp

    task automatic settle();
        @(negedge clk_sys_i);
    endtask : settle

    task automatic wr(input int which, input logic [7:0] d, input logic [1:0] sel);
        @(posedge clk_sys_i);
        wr_vec <= 6'(6'h01 << which);
        wdata <= d;
        port_sel <= sel;
        @(posedge clk_sys_i);
        wr_vec <= 6'h00;
    endtask : wr

    task automatic wait_rst(input logic lvl);
        int n;
        n = 0;
        while (reset_o !== lvl && n < 200) begin
            @(negedge clk_sys_i);
            n++;
        end
        if (n == 200) compare_flag(lvl, reset_o);
    endtask : wait_rst

    task automatic pin_reset(input logic [7:0] exp_power_control_reg);
        fork
            partner_u.hold_pin(36);
        join_none
        wait_rst(1'b1);
        note_exp(ID_PORT, {4{mcr_pkg::PORT_RST}}); // ports all ones
        note_exp(ID_P4, mcr_pkg::PORT4_RST); // short port ones
        note_exp(ID_SP, mcr_pkg::SP_RST); // stack pointer seven
        note_exp(ID_POWER_CONTROL_REG, exp_power_control_reg); // bit four kept
        note_exp(ID_SFR, mcr_pkg::SFR_RST); // others cleared
        note_exp(ID_SERIAL_BUFFER_REG, exp_serial_buffer_reg); // serial buffer kept
        note_exp(ID_ALEOE, 0); // latch strobe released
        note_exp(ID_PSOE, 0); // store strobe released
        settle();
        wait_rst(1'b0);
        note_exp(ID_PD, 0); // reset ends power-down
        note_exp(ID_OSC, 1); // oscillator back
        note_exp(ID_ALEOE, 1); // driven again
        settle();
    endtask : pin_reset

    task automatic results();
        if (errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    // the full sequence needs well under a thousand cycles
    initial begin
        repeat (6000) @(posedge clk_sys_i);
        errors++;
        results();
    end

    initial begin
        reset_i = 1'b1;
        xdata_access = 1'b0;
        code_fetch = 1'b1;
        wr_vec = 6'h00;
        port_sel = 2'h0;
        wdata = 8'h00;
        cnt_clr = 1'b0;
        rnd = 32'h43787E53;
        repeat (15) @(posedge clk_sys_i);
        note_exp(ID_PORT, {4{mcr_pkg::PORT_RST}}); // ports all ones
        note_exp(ID_SP, mcr_pkg::SP_RST); // stack pointer seven
        note_exp(ID_POWER_CONTROL_REG, mcr_pkg::POWER_CONTROL_REG_RST); // control cleared
        note_exp(ID_SFR, mcr_pkg::SFR_RST); // others cleared
        note_exp(ID_PSOE, 0); // store strobe released
        settle();
        @(posedge clk_sys_i);
        reset_i <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            wr(W_PORT, rnd[7:0], 2'(k));
            exp_port[k * 8 +: 8] = rnd[7:0];
        end
        rnd = lfsr(rnd);
        exp_sp = rnd[7:0];
        exp_sfr = rnd[15:8];
        exp_serial_buffer_reg = rnd[23:16];
        exp_p4 = rnd[27:24];
        wr(W_SP, exp_sp, 2'h0);
        wr(W_SFR, exp_sfr, 2'h0);
        wr(W_SERIAL_BUFFER_REG, exp_serial_buffer_reg, 2'h0);
        wr(W_P4, {4'h0, exp_p4}, 2'h0);
        wr(W_POWER_CONTROL_REG, 8'h10, 2'h0);
        note_exp(ID_PORT, exp_port);
        note_exp(ID_SP, exp_sp);
        note_exp(ID_SFR, exp_sfr);
        note_exp(ID_SERIAL_BUFFER_REG, exp_serial_buffer_reg);
        note_exp(ID_P4, exp_p4);
        settle();
        partner_u.hold_pin(11);
        repeat (30) @(posedge clk_sys_i);
        note_exp(ID_RST, 0); // one sample ignored
        note_exp(ID_SP, exp_sp); // nothing reloaded
        settle();
        pin_reset(8'h10);
        for (int w = 0; w < 2; w++) begin
            @(posedge clk_sys_i);
            xdata_access <= w[0];
            code_fetch <= ~w[0];
            repeat (24) @(posedge clk_sys_i);
            cnt_clr <= 1'b1;
            @(posedge clk_sys_i);
            cnt_clr <= 1'b0;
            repeat (120) @(posedge clk_sys_i);
            note_exp(ID_ALEN, (w == 0) ? 32'd20 : 32'd10); // sixth rate, skip
            note_exp(ID_LOWN, (w == 0) ? 32'd60 : 32'd0); // six per cycle
            note_exp(ID_TOGN, 32'd120); // halved clock
            note_exp(ID_MC, 32'd10); // six states a cycle
            settle();
        end
        wr(W_POWER_CONTROL_REG, 8'h11, 2'h0);
        repeat (2) @(posedge clk_sys_i);
        note_exp(ID_IDLE, 1); // idle entered
        note_exp(ID_CORE, 0); // core clock stopped
        note_exp(ID_PERI, 1); // peripherals run
        wr(W_SP, 8'hA5, 2'h0);
        note_exp(ID_SP, mcr_pkg::SP_RST); // core write refused
        partner_u.raise_irq();
        @(posedge clk_sys_i);
        note_exp(ID_IDLE, 0); // interrupt wakes
        note_exp(ID_CORE, 1); // core clock back
        note_exp(ID_POWER_CONTROL_REG, 8'h10); // idle bit cleared
        settle();
        wr(W_POWER_CONTROL_REG, 8'h12, 2'h0);
        repeat (2) @(posedge clk_sys_i);
        note_exp(ID_PD, 1); // power-down entered
        note_exp(ID_OSC, 0); // oscillator stopped
        note_exp(ID_CORE, 0); // core clock stopped
        partner_u.raise_irq();
        repeat (4) @(posedge clk_sys_i);
        note_exp(ID_PD, 1); // interrupt ignored
        settle();
        pin_reset(8'h10);
        results();
    end
endmodule : mcr_ctrl_tb
